// ---- common/pll_cfg_pkg.sv ----
// Purpose: Shared constants for the clock source configuration block
// Assumes: Register bus is APB with 32-bit data, one word per register
// Notes:   Printed offsets are register indices; byte address = 4 * index
//
// What this block does
// - Loop power field 00b runs the loop; 01b powers the loop down.
// - Bypass bit 0 feeds distribution through VCO divider; 1 bypasses it.
// - Source bit 1 selects internal VCO; 0 selects external clock input.
// - Three-bit ratio field selects VCO division by 2, 3, 4, 5 or 6.
// - Staged values take effect only when update is written with bit 0 set.
// - Calibration starts when calibrate bit is 1 and update is written, unless it already ran with no update at 0 between.
// - Polarity bit 0 gives positive detector polarity, 1 negative.
// - Two-bit field sets the detector antibacklash pulse width.
// - Pump mode: high impedance, normal, constant up or constant down.
// - Pump current selectable in eight steps, 600 uA to 4.8 mA.
// - Detector compares reference and feedback, commands pump up or down.
// - Ratio value 010b selects divide by four and is the reset default.
// - Reset: loop powered down, divider used, external clock source.

package pll_cfg_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          ADDR_W          = 12;
  localparam int          IDX_W           = 10;
  localparam logic [9:0]  IDX_LOOP_CTRL   = 10'h010;
  localparam logic [9:0]  IDX_ANTIBACKLASH= 10'h017;
  localparam logic [9:0]  IDX_VCO_CAL     = 10'h018;
  localparam logic [9:0]  IDX_VCO_DIV     = 10'h1e0;
  localparam logic [9:0]  IDX_CLK_SRC     = 10'h1e1;
  localparam logic [9:0]  IDX_UPDATE      = 10'h232;
  localparam logic [9:0]  IDX_PUMP_CUR    = 10'h240;
  localparam logic [9:0]  IDX_STATUS      = 10'h241;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int LOOP_PWR_LSB  = 0;
  localparam int PUMP_MODE_LSB = 4;
  localparam int POLARITY_BIT  = 7;
  localparam int CAL_BIT       = 0;
  localparam int BYPASS_BIT    = 0;
  localparam int SRC_VCO_BIT   = 1;
  localparam int UPDATE_BIT    = 0;

  // ****************************************************************
  // Encodings and reset values
  // ****************************************************************
  localparam logic [1:0] LOOP_PWR_NORMAL = 2'h0;
  localparam logic [1:0] LOOP_PWR_DOWN   = 2'h1;
  localparam logic [2:0] DIV_RATIO_MAX   = 3'h4;
  localparam logic [2:0] DIV_BASE        = 3'h2;
  localparam logic [7:0] RST_LOOP_CTRL   = 8'h01;
  localparam logic [7:0] RST_VCO_DIV     = 8'h02;
  localparam logic [7:0] RST_CLK_SRC     = 8'h00;
  localparam logic [7:0] RST_ZERO        = 8'h00;

  typedef enum logic [2:0] {
    PUMP_HIGH_Z, PUMP_NORMAL, PUMP_UP, PUMP_DOWN
  } pump_mode_t;

  // Pump mode field codes
  localparam logic [2:0] CODE_HIGH_Z = 3'h0;
  localparam logic [2:0] CODE_NORMAL = 3'h1;
  localparam logic [2:0] CODE_UP     = 3'h2;
  localparam logic [2:0] CODE_DOWN   = 3'h3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ        = 40;
  localparam int CAL_TIME_US    = 100;
  localparam int CAL_CYCLES     = CAL_TIME_US * CLK_MHZ;
  localparam int AB_BASE_CYCLES = 1;

endpackage : pll_cfg_pkg

// ---- logic/phase_freq_detector.sv ----
// Purpose: Digital phase frequency detector with antibacklash hold
// Assumes: Edge inputs are one-cycle pulses on the system clock
// Notes:   Both outputs stay high together for the antibacklash width
`timescale 1ns/1ps
`default_nettype none

module phase_freq_detector
  import pll_cfg_pkg::*;
#(
  parameter int AB_W = 2
) (
  // Clock and reset
  input  wire logic            sys_clk_i,
  input  wire logic            rst_i,
  // Control
  input  wire logic            enable_i,
  input  wire logic [AB_W-1:0] ab_sel_i,
  // Compared edges
  input  wire logic            ref_edge_i,
  input  wire logic            fb_edge_i,
  // Raw pump commands
  output logic                 up_o,
  output logic                 dn_o
);

  logic            up_ff;
  logic            dn_ff;
  logic [AB_W:0]   ab_cnt_ff;
  logic [AB_W:0]   ab_len;
  logic            both;
  logic            ab_done;

  assign ab_len  = {1'b0, ab_sel_i} + (AB_W+1)'(AB_BASE_CYCLES);
  assign both    = up_ff & dn_ff;
  assign ab_done = both && (ab_cnt_ff >= ab_len - (AB_W+1)'(1));

  // Set wins over reset so an edge in the clearing cycle is kept
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !enable_i) begin
      up_ff     <= 1'b0;
      dn_ff     <= 1'b0;
      ab_cnt_ff <= '0;
    end else begin
      up_ff     <= ref_edge_i | (up_ff & ~ab_done);
      dn_ff     <= fb_edge_i | (dn_ff & ~ab_done);
      ab_cnt_ff <= (both && !ab_done) ? ab_cnt_ff + (AB_W+1)'(1) : '0;
    end
  end

  assign up_o = up_ff;
  assign dn_o = dn_ff;

endmodule : phase_freq_detector
`default_nettype wire

// ---- logic/pll_clock_source_config.sv ----
// Purpose: Staged PLL and clock source configuration behind APB
// Assumes: Divider outputs arrive asynchronously as levels from counters
// Notes:   Zero-wait APB; writes land in staging, update applies them
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module pll_clock_source_config
  import pll_cfg_pkg::*;
#(
  parameter int CAL_LEN = CAL_CYCLES
) (
  // Clock and reset
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_i,
  // APB slave
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [pll_cfg_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]              pwdata_i,
  output logic [31:0]                   prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  // Divider outputs compared by the detector
  input  wire logic                     ref_div_i,
  input  wire logic                     fb_div_i,
  // Applied configuration
  output logic                          loop_power_down_o,
  output logic                          vco_div_bypass_o,
  output logic                          src_internal_vco_o,
  output logic [2:0]                    vco_div_value_o,
  output logic                          polarity_neg_o,
  output logic [1:0]                    antibacklash_o,
  output logic [2:0]                    pump_current_o,
  output logic                          pump_high_z_o,
  // Pump drive and calibration
  output logic                          charge_pump_up_o,
  output logic                          charge_pump_dn_o,
  output logic                          vco_cal_run_o
);

  // The calibration counter is 16 bits wide
  if (CAL_LEN < 1 || CAL_LEN > 65535) begin : g_bad_cal_len
    $error("CAL_LEN out of range");
  end

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic [IDX_W-1:0] idx;
  logic             setup;
  logic             wr_en;
  logic             hit_loop;
  logic             hit_ab;
  logic             hit_cal;
  logic             hit_div;
  logic             hit_src;
  logic             hit_upd;
  logic             hit_cur;
  logic             hit_sts;
  logic             mapped;

  assign idx      = paddr_i[ADDR_W-1:2];
  assign setup    = psel_i & ~penable_i;
  assign wr_en    = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
  assign hit_loop = (idx == IDX_LOOP_CTRL);
  assign hit_ab   = (idx == IDX_ANTIBACKLASH);
  assign hit_cal  = (idx == IDX_VCO_CAL);
  assign hit_div  = (idx == IDX_VCO_DIV);
  assign hit_src  = (idx == IDX_CLK_SRC);
  assign hit_upd  = (idx == IDX_UPDATE);
  assign hit_cur  = (idx == IDX_PUMP_CUR);
  assign hit_sts  = (idx == IDX_STATUS);
  assign mapped   = hit_loop | hit_ab | hit_cal | hit_div | hit_src |
                    hit_upd | hit_cur | hit_sts;

  // ****************************************************************
  // Staging registers
  // ****************************************************************
  logic [7:0] stg_loop_ff;
  logic [7:0] stg_ab_ff;
  logic [7:0] stg_cal_ff;
  logic [7:0] stg_div_ff;
  logic [7:0] stg_src_ff;
  logic [7:0] stg_cur_ff;
  logic       upd_req;

  // Update is a command: it leaves no stored bit, so it reads back zero
  assign upd_req = wr_en & hit_upd & pwdata_i[UPDATE_BIT];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stg_loop_ff <= RST_LOOP_CTRL;
      stg_ab_ff   <= RST_ZERO;
      stg_cal_ff  <= RST_ZERO;
      stg_div_ff  <= RST_VCO_DIV;
      stg_src_ff  <= RST_CLK_SRC;
      stg_cur_ff  <= RST_ZERO;
    end else if (wr_en) begin
      if (hit_loop) stg_loop_ff <= pwdata_i[7:0];
      if (hit_ab)   stg_ab_ff   <= pwdata_i[7:0];
      if (hit_cal)  stg_cal_ff  <= pwdata_i[7:0];
      if (hit_div)  stg_div_ff  <= pwdata_i[7:0];
      if (hit_src)  stg_src_ff  <= pwdata_i[7:0];
      if (hit_cur)  stg_cur_ff  <= pwdata_i[7:0];
    end
  end

  // ****************************************************************
  // Active registers, copied in one step on update
  // ****************************************************************
  logic [7:0] act_loop_ff;
  logic [7:0] act_ab_ff;
  logic       act_cal_ff;
  logic [7:0] act_div_ff;
  logic [7:0] act_src_ff;
  logic [7:0] act_cur_ff;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      act_loop_ff <= RST_LOOP_CTRL;
      act_ab_ff   <= RST_ZERO;
      act_cal_ff  <= 1'b0;
      act_div_ff  <= RST_VCO_DIV;
      act_src_ff  <= RST_CLK_SRC;
      act_cur_ff  <= RST_ZERO;
    end else if (upd_req) begin
      act_loop_ff <= stg_loop_ff;
      act_ab_ff   <= stg_ab_ff;
      act_cal_ff  <= stg_cal_ff[CAL_BIT];
      act_div_ff  <= stg_div_ff;
      act_src_ff  <= stg_src_ff;
      act_cur_ff  <= stg_cur_ff;
    end
  end

  // ****************************************************************
  // VCO calibration
  // ****************************************************************
  // A new run needs the bit seen low at an update first; a bit left
  // high across updates does not retrigger the analog sequence.
  logic        cal_armed_ff;
  logic        cal_busy_ff;
  logic        cal_done_ff;
  logic [15:0] cal_cnt_ff;
  logic        cal_start;
  logic        cal_end;

  assign cal_start = upd_req & stg_cal_ff[CAL_BIT] & cal_armed_ff
                     & ~cal_busy_ff;
  assign cal_end   = cal_busy_ff && (cal_cnt_ff == 16'(CAL_LEN - 1));

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cal_armed_ff <= 1'b1;
      cal_busy_ff  <= 1'b0;
      cal_done_ff  <= 1'b0;
      cal_cnt_ff   <= 16'h0000;
    end else begin
      if (cal_start) begin
        cal_armed_ff <= 1'b0;
      end else if (upd_req && !stg_cal_ff[CAL_BIT]) begin
        cal_armed_ff <= 1'b1;
      end
      if (cal_start) begin
        cal_busy_ff <= 1'b1;
        cal_done_ff <= 1'b0;
        cal_cnt_ff  <= 16'h0000;
      end else if (cal_end) begin
        cal_busy_ff <= 1'b0;
        cal_done_ff <= 1'b1;
      end else if (cal_busy_ff) begin
        cal_cnt_ff  <= cal_cnt_ff + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Decoded configuration
  // ****************************************************************
  logic       pwr_down;
  logic [2:0] ratio;
  logic [2:0] div_value;
  logic [2:0] mode_code;
  pump_mode_t pump_mode;

  // Only 00b runs the loop; other codes fail safe to powered down
  assign pwr_down  = act_loop_ff[LOOP_PWR_LSB +: 2] != LOOP_PWR_NORMAL;
  assign ratio     = (act_div_ff[2:0] > DIV_RATIO_MAX) ? DIV_RATIO_MAX
                                                       : act_div_ff[2:0];
  assign div_value = ratio + DIV_BASE;
  assign mode_code = act_loop_ff[PUMP_MODE_LSB +: 3];
  assign pump_mode = (mode_code == CODE_NORMAL) ? PUMP_NORMAL :
                     (mode_code == CODE_UP)     ? PUMP_UP     :
                     (mode_code == CODE_DOWN)   ? PUMP_DOWN   :
                                                  PUMP_HIGH_Z;

  // ****************************************************************
  // Divider edge capture
  // ****************************************************************
  logic [2:0] ref_sync_ff;
  logic [2:0] fb_sync_ff;
  logic       ref_edge;
  logic       fb_edge;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ref_sync_ff <= 3'h0;
      fb_sync_ff  <= 3'h0;
    end else begin
      ref_sync_ff <= {ref_sync_ff[1:0], ref_div_i};
      fb_sync_ff  <= {fb_sync_ff[1:0], fb_div_i};
    end
  end

  assign ref_edge = ref_sync_ff[1] & ~ref_sync_ff[2];
  assign fb_edge  = fb_sync_ff[1] & ~fb_sync_ff[2];

  // ****************************************************************
  // Detector and pump drive
  // ****************************************************************
  logic raw_up;
  logic raw_dn;
  logic pol_up;
  logic pol_dn;
  logic nxt_up;
  logic nxt_dn;

  phase_freq_detector #(
    .AB_W       (2)
  ) u_detector (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .enable_i   (~pwr_down),
    .ab_sel_i   (act_ab_ff[1:0]),
    .ref_edge_i (ref_edge),
    .fb_edge_i  (fb_edge),
    .up_o       (raw_up),
    .dn_o       (raw_dn)
  );

  // Negative polarity swaps the sense of the pump commands
  assign pol_up = act_loop_ff[POLARITY_BIT] ? raw_dn : raw_up;
  assign pol_dn = act_loop_ff[POLARITY_BIT] ? raw_up : raw_dn;

  always_comb begin
    nxt_up = 1'b0;
    nxt_dn = 1'b0;
    if (!pwr_down) begin
      case (pump_mode)
        PUMP_NORMAL: begin
          nxt_up = pol_up;
          nxt_dn = pol_dn;
        end
        PUMP_UP:     nxt_up = 1'b1;
        PUMP_DOWN:   nxt_dn = 1'b1;
        default: begin
          nxt_up = 1'b0;
          nxt_dn = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      loop_power_down_o  <= 1'b1;
      vco_div_bypass_o   <= 1'b0;
      src_internal_vco_o <= 1'b0;
      vco_div_value_o    <= DIV_BASE + RST_VCO_DIV[2:0];
      polarity_neg_o     <= 1'b0;
      antibacklash_o     <= 2'h0;
      pump_current_o     <= 3'h0;
      pump_high_z_o      <= 1'b1;
      charge_pump_up_o   <= 1'b0;
      charge_pump_dn_o   <= 1'b0;
      vco_cal_run_o      <= 1'b0;
    end else begin
      loop_power_down_o  <= pwr_down;
      vco_div_bypass_o   <= act_src_ff[BYPASS_BIT];
      src_internal_vco_o <= act_src_ff[SRC_VCO_BIT];
      vco_div_value_o    <= div_value;
      polarity_neg_o     <= act_loop_ff[POLARITY_BIT];
      antibacklash_o     <= act_ab_ff[1:0];
      pump_current_o     <= act_cur_ff[2:0];
      pump_high_z_o      <= pwr_down | (pump_mode == PUMP_HIGH_Z);
      charge_pump_up_o   <= nxt_up;
      charge_pump_dn_o   <= nxt_dn;
      vco_cal_run_o      <= cal_busy_ff | cal_start;
    end
  end

  // ****************************************************************
  // APB answer
  // ****************************************************************
  logic [31:0] rd_mux;
  logic [7:0]  status;

  assign status = {2'h0, act_cal_ff, cal_armed_ff, cal_done_ff,
                   cal_busy_ff, act_src_ff[SRC_VCO_BIT], pwr_down};
  assign rd_mux = hit_loop ? {24'h0, stg_loop_ff} :
                  hit_ab   ? {24'h0, stg_ab_ff}   :
                  hit_cal  ? {24'h0, stg_cal_ff}  :
                  hit_div  ? {24'h0, stg_div_ff}  :
                  hit_src  ? {24'h0, stg_src_ff}  :
                  hit_cur  ? {24'h0, stg_cur_ff}  :
                  hit_sts  ? {24'h0, status}      : 32'h0000_0000;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup & ~mapped;
      if (setup) begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : rd_mux;
      end
    end
  end

endmodule : pll_clock_source_config
`default_nettype wire

// ---- test/pll_cfg_asserts.sv ----
// Purpose: Port-level checks for the staged clock configuration
// Assumes: Zero-wait APB; applied outputs move one cycle after update
// Notes:   Bound onto the top module below
`timescale 1ns/1ps
`default_nettype none
module pll_cfg_asserts
  import pll_cfg_pkg::*;
#(
  parameter int CAL_LEN = 8
) (
  // Clock, reset and bus
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Applied configuration and pump
  input wire logic        loop_power_down_o,
  input wire logic        vco_div_bypass_o,
  input wire logic        src_internal_vco_o,
  input wire logic [2:0]  vco_div_value_o,
  input wire logic        polarity_neg_o,
  input wire logic [1:0]  antibacklash_o,
  input wire logic [2:0]  pump_current_o,
  input wire logic        pump_high_z_o,
  input wire logic        charge_pump_up_o,
  input wire logic        charge_pump_dn_o,
  input wire logic        vco_cal_run_o
);
  wire logic        upd_acc;
  wire logic [12:0] cfg;
  logic      [16:0] run_cnt_ff;
  assign upd_acc = psel_i & penable_i & pready_o & pwrite_i
                   & (paddr_i[11:2] == IDX_UPDATE) & pwdata_i[UPDATE_BIT];
  assign cfg = {loop_power_down_o, vco_div_bypass_o, src_internal_vco_o,
                vco_div_value_o, polarity_neg_o, antibacklash_o,
                pump_current_o, pump_high_z_o};
  // Length of the current calibration run
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !vco_cal_run_o) run_cnt_ff <= 17'h0;
    else run_cnt_ff <= run_cnt_ff + 17'h1;
  end
  default clocking dc @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  chk_ready_setup: assert property (
    psel_i && !penable_i |=> pready_o) else $error("no ready after setup");
  chk_ready_only: assert property (
    pready_o |-> $past(psel_i && !penable_i)) else $error("stray ready");
  chk_err_ready: assert property (
    pslverr_o |-> pready_o) else $error("error without ready");
  chk_reset_vals: assert property (
    $fell(rst_i) |-> cfg == 13'h1201) else $error("bad reset outputs");
  chk_staged_only: assert property (
    $changed(cfg) && !$past(rst_i) |-> $past(upd_acc) || $past(upd_acc, 2))
    else $error("config moved without update");
  chk_div_range: assert property (
    vco_div_value_o inside {[3'h2:3'h6]}) else $error("divider out of range");
  chk_pd_highz: assert property (
    loop_power_down_o && $past(loop_power_down_o) |-> pump_high_z_o)
    else $error("pump driven while powered down");
  chk_cal_start: assert property (
    $rose(vco_cal_run_o) |-> $past(upd_acc) || $past(upd_acc, 2))
    else $error("calibration without update");
  chk_cal_len: assert property (
    $fell(vco_cal_run_o) |-> run_cnt_ff == 17'(CAL_LEN + 1))
    else $error("calibration length wrong");
  cover property (upd_acc);
  cover property ($rose(vco_cal_run_o));
  cover property (pslverr_o);
  cover property (charge_pump_up_o && charge_pump_dn_o);
endmodule : pll_cfg_asserts

bind pll_clock_source_config pll_cfg_asserts #(.CAL_LEN(CAL_LEN)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .loop_power_down_o(loop_power_down_o), .vco_div_bypass_o(vco_div_bypass_o),
  .src_internal_vco_o(src_internal_vco_o), .vco_div_value_o(vco_div_value_o),
  .polarity_neg_o(polarity_neg_o), .antibacklash_o(antibacklash_o),
  .pump_current_o(pump_current_o), .pump_high_z_o(pump_high_z_o),
  .charge_pump_up_o(charge_pump_up_o), .charge_pump_dn_o(charge_pump_dn_o),
  .vco_cal_run_o(vco_cal_run_o));
`default_nettype wire

// ---- test/ref_fb_source.sv ----
// Purpose: Reference and feedback counter outputs seen by the detector
// Assumes: Both counters run at one rate; feedback lags by lag_i cycles when fb_first_i is low, reference lags when high
// Notes:   Outputs rest low while disabled, as idle counters would
`timescale 1ns/1ps
`default_nettype none
module ref_fb_source #(
  parameter int PERIOD = 16
) (
  // Clock and control
  input  wire logic       sys_clk_i,
  input  wire logic       en_i,
  input  wire logic       fb_first_i,
  input  wire logic [3:0] lag_i,
  // Counter outputs
  output logic            ref_div_o,
  output logic            fb_div_o
);
  logic [7:0] cnt_ff;
  wire logic  lead;
  wire logic  late;
  always_ff @(posedge sys_clk_i) begin
    if (!en_i || cnt_ff == 8'(PERIOD - 1)) cnt_ff <= 8'h00;
    else cnt_ff <= cnt_ff + 8'h01;
  end
  // Lag must stay below half a period or the edges wrap
  assign lead = en_i && cnt_ff < 8'(PERIOD / 2);
  assign late = en_i && cnt_ff >= {4'h0, lag_i}
                && cnt_ff < 8'(PERIOD / 2) + {4'h0, lag_i};
  assign ref_div_o = fb_first_i ? late : lead;
  assign fb_div_o  = fb_first_i ? lead : late;
endmodule : ref_fb_source
`default_nettype wire

// ---- test/tb_pll_clock_source_config.sv ----
// Purpose: Self-checking bench for the staged clock configuration
// Assumes: Zero-wait APB, CAL_LEN shortened to 8
// Notes:   Rows cover every ratio and pump mode; edge cases follow
`timescale 1ns/1ps
`default_nettype none
module tb_pll_clock_source_config;
  import pll_cfg_pkg::*;
  localparam int CAL_N = 8;
  localparam logic [31:0] DEF = 32'h1201;
  typedef struct packed {
    logic [7:0]  loop, src, div, ab, cur;
    logic [31:0] exp;
  } row_t;
  // Ratio 7 checks saturation; mode 5 checks spare codes go high-Z
  row_t rows [6] = '{
    '{8'h10, 8'h02, 8'h00, 8'h00, 8'h00, 32'h0500},
    '{8'h80, 8'h01, 8'h01, 8'h01, 8'h01, 32'h09d3},
    '{8'h21, 8'h01, 8'h02, 8'h02, 8'h07, 32'h1a2f},
    '{8'h30, 8'h00, 8'h03, 8'h03, 8'h05, 32'h02ba},
    '{8'h12, 8'h02, 8'h04, 8'h00, 8'h02, 32'h1705},
    '{8'h50, 8'h00, 8'h07, 8'h02, 8'h03, 32'h0327}};
  logic        sys_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [11:0] paddr_i   = 12'h000;
  logic [31:0] pwdata_i  = 32'h0;
  logic        en        = 1'b0;
  logic [31:0] prdata_o, r, prev;
  logic        pready_o, pslverr_o, e, ref_div, fb_div;
  logic        pd, byp, src, pol, hz, up, dn, cal;
  logic [2:0]  div, cur;
  logic [1:0]  ab;
  int          error_cnt = 0;
  int          n_tests   = 0;
  int          u, d;
  wire logic [31:0] cfg = {19'h0, pd, byp, src, div, pol, ab, cur, hz};
  always #12.5 sys_clk_i = ~sys_clk_i;
  pll_clock_source_config #(.CAL_LEN(CAL_N)) DUT (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .ref_div_i(ref_div), .fb_div_i(fb_div),
    .loop_power_down_o(pd), .vco_div_bypass_o(byp),
    .src_internal_vco_o(src), .vco_div_value_o(div), .polarity_neg_o(pol),
    .antibacklash_o(ab), .pump_current_o(cur), .pump_high_z_o(hz),
    .charge_pump_up_o(up), .charge_pump_dn_o(dn), .vco_cal_run_o(cal));
  ref_fb_source #(.PERIOD(16)) u_src (
    .sys_clk_i(sys_clk_i), .en_i(en), .fb_first_i(1'b0), .lag_i(4'h4),
    .ref_div_o(ref_div), .fb_div_o(fb_div));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic print_verdict;
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd,
                     output logic er);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= {idx, 2'b00};
    pwdata_i <= {24'h0, wd};
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    // Answer taken at the rising edge that samples pready; no wait limit
    // here, the watchdog ends a hang
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
    logic [31:0] rr;
    logic        ee;
    apb(1'b1, idx, wd, rr, ee);
  endtask : wr
  task automatic upd;
    wr(IDX_UPDATE, 8'h01);
    repeat (2) @(negedge sys_clk_i);
  endtask : upd
  task automatic cal_len(output int len);
    int n;
    n = 0;
    len = 0;
    while (cal !== 1'b1 && n++ < 10) @(negedge sys_clk_i);
    while (cal === 1'b1 && len < 50) begin
      @(negedge sys_clk_i);
      len++;
    end
  endtask : cal_len
  task automatic measure;
    u = 0;
    d = 0;
    repeat (128) begin
      @(negedge sys_clk_i);
      u += int'(up);
      d += int'(dn);
    end
  endtask : measure
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    error_cnt++;
    print_verdict();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(negedge sys_clk_i);
    chk("reset cfg", DEF, cfg);
    prev = DEF;
    foreach (rows[k]) begin
      wr(IDX_LOOP_CTRL, rows[k].loop);
      wr(IDX_CLK_SRC, rows[k].src);
      wr(IDX_VCO_DIV, rows[k].div);
      wr(IDX_ANTIBACKLASH, rows[k].ab);
      wr(IDX_PUMP_CUR, rows[k].cur);
      chk("held cfg", prev, cfg);
      apb(1'b0, IDX_LOOP_CTRL, 8'h00, r, e);
      chk("staged", {24'h0, rows[k].loop}, r);
      upd();
      chk("cfg", rows[k].exp, cfg);
      prev = rows[k].exp;
    end
    apb(1'b1, 10'h3ff, 8'hff, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    apb(1'b0, IDX_UPDATE, 8'h00, r, e);
    chk("update clears", 32'h0, r);
    wr(IDX_LOOP_CTRL, 8'h20);
    upd();
    chk("pump up", 32'h2, {30'h0, up, dn});
    wr(IDX_LOOP_CTRL, 8'h30);
    upd();
    chk("pump down", 32'h1, {30'h0, up, dn});
    wr(IDX_ANTIBACKLASH, 8'h00);
    wr(IDX_LOOP_CTRL, 8'h10);
    upd();
    @(posedge sys_clk_i);
    en <= 1'b1;
    measure();
    chk("ref leads", 32'h1, {31'h0, u > d});
    prev = d;
    wr(IDX_ANTIBACKLASH, 8'h03);
    wr(IDX_LOOP_CTRL, 8'h90);
    upd();
    measure();
    chk("neg polarity", 32'h1, {31'h0, d > u});
    chk("ab width", 32'h1, {31'h0, u > 2 * prev});
    @(posedge sys_clk_i);
    en <= 1'b0;
    wr(IDX_VCO_CAL, 8'h01);
    wr(IDX_UPDATE, 8'h01);
    cal_len(u);
    chk("cal len", CAL_N + 1, u);
    apb(1'b0, IDX_STATUS, 8'h00, r, e);
    chk("cal done", 32'h1, {31'h0, r[3]});
    wr(IDX_UPDATE, 8'h01);
    cal_len(u);
    chk("no rearm", 32'h0, u);
    wr(IDX_VCO_CAL, 8'h00);
    upd();
    wr(IDX_VCO_CAL, 8'h01);
    wr(IDX_UPDATE, 8'h01);
    cal_len(u);
    chk("recal len", CAL_N + 1, u);
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(negedge sys_clk_i);
    chk("rerst cfg", DEF, cfg);
    apb(1'b0, IDX_LOOP_CTRL, 8'h00, r, e);
    chk("rst loop", 32'h01, r);
    apb(1'b0, IDX_VCO_DIV, 8'h00, r, e);
    chk("rst div", 32'h02, r);
    apb(1'b0, IDX_CLK_SRC, 8'h00, r, e);
    chk("rst src", 32'h00, r);
    print_verdict();
  end
endmodule : tb_pll_clock_source_config
`default_nettype wire
